// *** rtl/fcd_decoder.sv ***
`default_nettype none
module fcd_decoder (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_cmd_valid,
   input  wire logic [15:0]       i_cmd_word,
   output logic                   o_cmd_ready,
   input  wire logic [15:0]       i_float_control_reg,
   input  wire logic [31:0]       i_host_data,
   input  wire logic              i_host_data_valid,
   input  wire logic              i_exec_done,
   input  wire logic              i_exec_exception,
   output fcd_pkg::fcd_resp_t     o_resp,
   output logic                   o_resp_valid,
   input  wire logic              i_resp_ack,
   output fcd_pkg::fcd_work_t     o_work,
   output logic                   o_work_start
);
   import fcd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FIRST,
      ST_KWAIT,
      ST_EXEC,
      ST_STORE,
      ST_LAST
   } fcd_state_t;

   typedef struct packed {
      fcd_state_t  state;
      fcd_resp_t   resp;
      logic        resp_valid;
      fcd_work_t   work;
      logic        work_start;
      logic        skip_first;
      logic        dyn_k;
      logic        to_ext;
   } fcd_regs_t;

   fcd_regs_t regs_ff;
   fcd_regs_t nxt_regs;

   function automatic logic [3:0] fmt_length(input logic [2:0] fmt);
      case (fmt)
         FMT_LONG, FMT_SINGLE: fmt_length = LEN_4;
         FMT_WORD:             fmt_length = LEN_2;
         FMT_BYTE:             fmt_length = LEN_1;
         FMT_DOUBLE:           fmt_length = LEN_8;
         default:              fmt_length = LEN_12;
      endcase
   endfunction

   function automatic fcd_ea_t fmt_class(input logic [2:0] fmt);
      case (fmt)
         FMT_LONG, FMT_SINGLE, FMT_WORD, FMT_BYTE: fmt_class = EA_DATA;
         default:                                  fmt_class = EA_MEMORY;
      endcase
   endfunction

   // Defined arithmetic codes below 7'h40, redundant ones included.
   function automatic logic ext_defined(input logic [6:0] ext);
      ext_defined = ~ext[6];
   endfunction

   // Redundant codes fold onto a neighbouring valid operation.
   function automatic logic [6:0] ext_fold(input logic [6:0] ext);
      case (ext)
         7'h05, 7'h07, 7'h0B, 7'h13, 7'h17, 7'h1B: ext_fold = ext & 7'h7E;
         7'h39:                                 ext_fold = 7'h38;
         default:
         begin
            if (ext >= 7'h29 && ext <= 7'h2F)
               ext_fold = 7'h28;
            else if (ext >= 7'h3B && ext <= 7'h3F)
               ext_fold = 7'h3A;
            else
               ext_fold = ext;
         end
      endcase
   endfunction

   function automatic logic [3:0] ctrl_length(input logic [2:0] list);
      case (list)
         3'b011, 3'b101, 3'b110: ctrl_length = LEN_8;
         3'b111:                 ctrl_length = LEN_12;
         default:                ctrl_length = LEN_4;
      endcase
   endfunction

   function automatic logic ctrl_single(input logic [2:0] list);
      ctrl_single = (list == 3'b001) || (list == 3'b010) || (list == 3'b100) || (list == 3'b000);
   endfunction

   logic        exc_enabled;
   logic [2:0]  cls;
   logic [6:0]  ext;
   logic [2:0]  rx;
   logic [2:0]  ry;
   fcd_resp_t   first;
   fcd_resp_t   store;

   assign exc_enabled = |(i_float_control_reg[FLOAT_CONTROL_REG_ENABLE_HI-1:FLOAT_CONTROL_REG_ENABLE_LO]);
   assign cls = i_cmd_word[CLS_HI:CLS_LO];
   assign ext = i_cmd_word[EXT_HI:0];
   assign rx  = i_cmd_word[RX_HI:RX_LO];
   assign ry  = i_cmd_word[RY_HI:RY_LO];

   always_comb
   begin
      nxt_regs = regs_ff;
      nxt_regs.work_start = 1'b0;
      first = '0;
      store = '0;
      if (regs_ff.resp_valid && i_resp_ack)
         nxt_regs.resp_valid = 1'b0;
      case (regs_ff.state)
         ST_IDLE:
         begin
            if (i_cmd_valid)
            begin
               nxt_regs.work = '0;
               nxt_regs.dyn_k = 1'b0;
               nxt_regs.skip_first = 1'b0;
               nxt_regs.to_ext = (cls == CLS_TO_EXT);
               nxt_regs.work.src_reg = rx;
               nxt_regs.work.dst_reg = ry;
               nxt_regs.work.fmt = rx;
               first.come_again_bit = 1'b1;
               first.pass_counter_bit = exc_enabled;
               case (cls)
                  CLS_REG_REG:
                  begin
                     first.prim = PRIM_NULL;
                     if (!ext_defined(ext))
                     begin
                        first = '0;
                        first.prim = PRIM_PRE_EXC;
                        first.vector = UNIMP_VECTOR;
                     end
                     nxt_regs.work.opcode = ext_fold(ext);
                  end
                  CLS_EXT_REG:
                  begin
                     if (rx == FMT_PDYN)
                     begin
                        // Constant load: no external access, null only when enabled.
                        nxt_regs.work.const_load = 1'b1;
                        nxt_regs.work.rom_offset = ext;
                        first.prim = PRIM_NULL;
                        nxt_regs.skip_first = !exc_enabled;
                     end
                     else if (!ext_defined(ext))
                     begin
                        first.prim = PRIM_PRE_EXC;
                        first.come_again_bit = 1'b0;
                        first.pass_counter_bit = 1'b0;
                        first.vector = UNIMP_VECTOR;
                     end
                     else
                     begin
                        first.prim = PRIM_EVAL_XFER;
                        first.length = fmt_length(rx);
                        first.ea_class = fmt_class(rx);
                        nxt_regs.work.opcode = ext_fold(ext);
                     end
                  end
                  CLS_TO_EXT:
                  begin
                     if (rx == FMT_PDYN)
                     begin
                        first.prim = PRIM_XFER_HOST_REG;
                        first.host_reg = ext[DREG_HI:DREG_LO];
                        nxt_regs.dyn_k = 1'b1;
                     end
                     else
                     begin
                        first.prim = PRIM_NULL;
                        nxt_regs.skip_first = !exc_enabled;
                        if (rx == FMT_PACKED)
                           nxt_regs.work.k_factor = ext;
                     end
                     nxt_regs.work.src_reg = ry;
                     nxt_regs.work.dst_reg = ry;
                  end
                  CLS_CTRL, CLS_CTRL_RD:
                  begin
                     // Low ten bits are ignored rather than trapped.
                     nxt_regs.work.ctrl_list = rx;
                     nxt_regs.work.direction_bit = i_cmd_word[CTRL_DIR_BIT];
                     first.prim = PRIM_EVAL_XFER;
                     first.pass_counter_bit = 1'b0;
                     first.length = ctrl_length(rx);
                     first.dir_to_host = i_cmd_word[CTRL_DIR_BIT];
                     first.alterable = i_cmd_word[CTRL_DIR_BIT];
                     if (ctrl_single(rx))
                        first.ea_class = (rx == 3'b001 || rx == 3'b000) ? EA_ANY : EA_DATA;
                     else
                        first.ea_class = EA_MEMORY;
                  end
                  default:
                  begin
                     nxt_regs.work.direction_bit = i_cmd_word[CTRL_DIR_BIT];
                     nxt_regs.work.mult_dynamic = i_cmd_word[MULT_DYN_BIT];
                     nxt_regs.work.mult_list = i_cmd_word[7:0];
                     if (i_cmd_word[MULT_DYN_BIT])
                     begin
                        first.prim = PRIM_XFER_HOST_REG;
                        first.host_reg = i_cmd_word[DREG_HI:DREG_LO];
                        nxt_regs.dyn_k = 1'b1;
                     end
                     else
                     begin
                        first.prim = PRIM_XFER_MULT;
                        first.dir_to_host = i_cmd_word[CTRL_DIR_BIT];
                        first.ea_class = EA_CONTROL;
                     end
                     first.pass_counter_bit = 1'b0;
                  end
               endcase
               nxt_regs.resp = first;
               nxt_regs.resp_valid = !(nxt_regs.skip_first);
               nxt_regs.state = ST_FIRST;
            end
         end
         ST_FIRST:
         begin
            if (!regs_ff.resp_valid || i_resp_ack)
            begin
               if (regs_ff.resp.prim == PRIM_PRE_EXC)
               begin
                  nxt_regs.state = ST_IDLE;
               end
               else if (regs_ff.dyn_k)
               begin
                  nxt_regs.state = ST_KWAIT;
               end
               else
               begin
                  nxt_regs.work_start = 1'b1;
                  nxt_regs.state = ST_EXEC;
               end
            end
         end
         ST_KWAIT:
         begin
            if (i_host_data_valid)
            begin
               if (regs_ff.work.mult_dynamic)
                  nxt_regs.work.mult_list = i_host_data[7:0];
               else
                  nxt_regs.work.k_factor = i_host_data[6:0];
               nxt_regs.work_start = 1'b1;
               nxt_regs.state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            if (i_exec_done)
            begin
               store = '0;
               if (i_exec_exception)
                  store.prim = PRIM_MID_EXC;
               else if (regs_ff.to_ext)
               begin
                  // The converted operand goes out before the closing null, whatever its format.
                  store.prim = PRIM_EVAL_XFER;
                  store.come_again_bit = 1'b1;
                  store.length = fmt_length(regs_ff.work.fmt);
                  store.ea_class = fmt_class(regs_ff.work.fmt);
                  store.alterable = 1'b1;
                  store.dir_to_host = 1'b1;
               end
               else
                  store.prim = PRIM_NULL;
               nxt_regs.resp = store;
               nxt_regs.resp_valid = 1'b1;
               if (i_exec_exception || !regs_ff.to_ext)
                  nxt_regs.state = ST_LAST;
               else
                  nxt_regs.state = ST_STORE;
            end
         end
         ST_STORE:
         begin
            // Once the host has taken the operand, the dialog closes with a plain null.
            if (!regs_ff.resp_valid || i_resp_ack)
            begin
               nxt_regs.resp = '0;
               nxt_regs.resp_valid = 1'b1;
               nxt_regs.state = ST_LAST;
            end
         end
         ST_LAST:
         begin
            if (!regs_ff.resp_valid || i_resp_ack)
               nxt_regs.state = ST_IDLE;
         end
         default:
         begin
            nxt_regs.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         regs_ff <= '0;
      else
         regs_ff <= nxt_regs;
   end

   assign o_cmd_ready  = (regs_ff.state == ST_IDLE);
   assign o_resp       = regs_ff.resp;
   assign o_resp_valid = regs_ff.resp_valid;
   assign o_work       = regs_ff.work;
   assign o_work_start = regs_ff.work_start;
endmodule
`default_nettype wire

// *** rtl/fcd_pkg.sv ***
`default_nettype none
package fcd_pkg;
   // Command class, taken from command word bits 15:13.
   localparam logic [2:0] CLS_REG_REG   = 3'b000;
   localparam logic [2:0] CLS_EXT_REG   = 3'b010;
   localparam logic [2:0] CLS_TO_EXT    = 3'b011;
   localparam logic [2:0] CLS_CTRL      = 3'b100;
   localparam logic [2:0] CLS_CTRL_RD   = 3'b101;
   localparam logic [2:0] CLS_MULT_A    = 3'b110;
   localparam logic [2:0] CLS_MULT_B    = 3'b111;
   localparam logic [5:0] CONST_LOAD_OP = 6'h17;
   localparam int CLS_HI = 15;
   localparam int CLS_LO = 13;
   localparam int RX_HI  = 12;
   localparam int RX_LO  = 10;
   localparam int RY_HI  = 9;
   localparam int RY_LO  = 7;
   localparam int EXT_HI = 6;
   localparam int DREG_HI = 6;
   localparam int DREG_LO = 4;
   localparam int CTRL_DIR_BIT = 13;
   localparam int MULT_DYN_BIT = 11;
   // Formats shared by source and destination fields.
   localparam logic [2:0] FMT_LONG   = 3'b000;
   localparam logic [2:0] FMT_SINGLE = 3'b001;
   localparam logic [2:0] FMT_EXT    = 3'b010;
   localparam logic [2:0] FMT_PACKED = 3'b011;
   localparam logic [2:0] FMT_WORD   = 3'b100;
   localparam logic [2:0] FMT_DOUBLE = 3'b101;
   localparam logic [2:0] FMT_BYTE   = 3'b110;
   localparam logic [2:0] FMT_PDYN   = 3'b111;
   localparam logic [7:0] UNIMP_VECTOR = 8'h0B;
   localparam logic [3:0] LEN_1  = 4'h1;
   localparam logic [3:0] LEN_2  = 4'h2;
   localparam logic [3:0] LEN_4  = 4'h4;
   localparam logic [3:0] LEN_8  = 4'h8;
   localparam logic [3:0] LEN_12 = 4'hC;
   localparam int FLOAT_CONTROL_REG_ENABLE_HI = 15;
   localparam int FLOAT_CONTROL_REG_ENABLE_LO = 8;
   localparam int BRANCH_UNORDERED_FLAG_ENABLE_BIT = 15;
   typedef enum logic [2:0] {
      PRIM_NULL,
      PRIM_EVAL_XFER,
      PRIM_XFER_HOST_REG,
      PRIM_XFER_MULT,
      PRIM_PRE_EXC,
      PRIM_MID_EXC
   } fcd_prim_t;
   typedef enum logic [1:0] {
      EA_ANY,
      EA_DATA,
      EA_MEMORY,
      EA_CONTROL
   } fcd_ea_t;
   typedef enum logic [2:0] {
      KSRC_NONE,
      KSRC_STATIC,
      KSRC_DYNAMIC,
      KSRC_DONE
   } fcd_ksrc_t;
   // One response primitive sent to the host.
   typedef struct packed {
      fcd_prim_t   prim;
      logic        come_again_bit;
      logic        pass_counter_bit;
      logic        interrupt_allowed_bit;
      logic        alterable;
      fcd_ea_t     ea_class;
      logic [3:0]  length;
      logic        dir_to_host;
      logic [7:0]  vector;
      logic [2:0]  host_reg;
   } fcd_resp_t;
   // Decoded work handed to the datapath.
   typedef struct packed {
      logic [6:0]  opcode;
      logic [2:0]  src_reg;
      logic [2:0]  dst_reg;
      logic [2:0]  fmt;
      logic        const_load;
      logic [6:0]  rom_offset;
      logic [6:0]  k_factor;
      logic [2:0]  ctrl_list;
      logic        direction_bit;
      logic        mult_dynamic;
      logic [7:0]  mult_list;
   } fcd_work_t;
endpackage
`default_nettype wire

// *** dv/fcd_decoder_assertions.sv ***
`default_nettype none
module fcd_decoder_checker (
   input wire logic               i_clk,
   input wire logic               i_rst,
   input wire logic               i_cmd_valid,
   input wire logic [15:0]        i_cmd_word,
   input wire logic               o_cmd_ready,
   input wire logic [15:0]        i_float_control_reg,
   input wire logic               i_resp_ack,
   input wire fcd_pkg::fcd_resp_t o_resp,
   input wire logic               o_resp_valid,
   input wire fcd_pkg::fcd_work_t o_work,
   input wire logic               o_work_start
);
   import fcd_pkg::*;
   localparam logic [3:0] FLEN [8] = '{LEN_4, LEN_4, LEN_12, LEN_12, LEN_2, LEN_8, LEN_1, LEN_12};
   localparam logic [3:0] CLEN [8] = '{LEN_4, LEN_4, LEN_4, LEN_8, LEN_4, LEN_8, LEN_8, LEN_12};
   localparam logic [7:0] DATA_FMT = 8'h53;
   logic [15:0] cmd_ff;
   logic        en_ff;
   logic        take;
   logic        arith;
   logic        ev;
   assign take  = i_cmd_valid && o_cmd_ready;
   assign arith = i_cmd_word[15:13] == CLS_REG_REG ||
                  (i_cmd_word[15:13] == CLS_EXT_REG && i_cmd_word[15:10] != CONST_LOAD_OP);
   assign ev    = o_resp_valid && o_resp.prim == PRIM_EVAL_XFER;
   // The command and its enable state are held for the whole dialog.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         cmd_ff <= 16'h0000;
         en_ff  <= 1'b0;
      end
      else if (take)
      begin
         cmd_ff <= i_cmd_word;
         en_ff  <= |i_float_control_reg[14:8];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_reset_idle: assert property ($fell(i_rst) |-> o_cmd_ready && !o_resp_valid && !o_work_start)
      else $error("not idle after reset");
   a_first_regreg: assert property (take && i_cmd_word[15:13] == CLS_REG_REG && !i_cmd_word[6]
      |=> o_resp_valid && o_resp.prim == PRIM_NULL && o_resp.come_again_bit && o_resp.pass_counter_bit == en_ff)
      else $error("reg-reg first primitive wrong");
   a_first_ext: assert property (take && arith && i_cmd_word[15:13] == CLS_EXT_REG && !i_cmd_word[6]
      |=> ev && o_resp.come_again_bit && o_resp.pass_counter_bit == en_ff && o_resp.length == FLEN[cmd_ff[12:10]]
      && o_resp.ea_class == (DATA_FMT[cmd_ff[12:10]] ? EA_DATA : EA_MEMORY))
      else $error("ext-reg first primitive wrong");
   a_undef_trap: assert property (take && arith && i_cmd_word[6]
      |=> o_resp_valid && o_resp.prim == PRIM_PRE_EXC && o_resp.vector == UNIMP_VECTOR)
      else $error("undefined extension not trapped");
   a_const_first: assert property (take && i_cmd_word[15:10] == CONST_LOAD_OP && |i_float_control_reg[14:8]
      |=> o_resp_valid && o_resp.prim == PRIM_NULL && o_resp.come_again_bit && o_resp.pass_counter_bit)
      else $error("constant load primitive wrong");
   a_dyn_kreg: assert property (take && i_cmd_word[15:10] == {CLS_TO_EXT, FMT_PDYN}
      |=> o_resp_valid && o_resp.prim == PRIM_XFER_HOST_REG && o_resp.host_reg == cmd_ff[6:4])
      else $error("dynamic k register wrong");
   a_store_len: assert property (ev && cmd_ff[15:13] == CLS_TO_EXT |-> o_resp.length == FLEN[cmd_ff[12:10]]
      && o_resp.alterable && o_resp.ea_class == (DATA_FMT[cmd_ff[12:10]] ? EA_DATA : EA_MEMORY))
      else $error("store length or class wrong");
   a_ctrl_xfer: assert property (ev && cmd_ff[15:14] == 2'b10
      |-> o_resp.dir_to_host == cmd_ff[13] && o_resp.length == CLEN[cmd_ff[12:10]])
      else $error("control move transfer wrong");
   a_ctrl_notrap: assert property (o_resp_valid && cmd_ff[15:14] == 2'b10 |-> o_resp.prim != PRIM_PRE_EXC)
      else $error("control move trapped");
   a_resp_holds: assert property (o_resp_valid && !i_resp_ack |=> o_resp_valid && $stable(o_resp))
      else $error("primitive dropped before ack");
   a_regreg_regs: assert property (o_work_start && cmd_ff[15:13] == CLS_REG_REG
      |-> o_work.src_reg == cmd_ff[12:10] && o_work.dst_reg == cmd_ff[9:7])
      else $error("register fields wrong");
   a_const_rom: assert property (o_work_start && cmd_ff[15:10] == CONST_LOAD_OP
      |-> o_work.const_load && o_work.rom_offset == cmd_ff[6:0])
      else $error("constant offset wrong");
   a_static_k: assert property (o_work_start && cmd_ff[15:10] == {CLS_TO_EXT, FMT_PACKED}
      |-> o_work.k_factor == cmd_ff[6:0])
      else $error("static k wrong");
endmodule
bind fcd_decoder fcd_decoder_checker fcd_decoder_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word), .o_cmd_ready(o_cmd_ready),
   .i_float_control_reg(i_float_control_reg), .i_resp_ack(i_resp_ack), .o_resp(o_resp),
   .o_resp_valid(o_resp_valid), .o_work(o_work), .o_work_start(o_work_start));
`default_nettype wire

// *** dv/fcd_host_model.sv ***
`default_nettype none
module fcd_host_model (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire fcd_pkg::fcd_resp_t i_resp,
   input  wire logic               i_resp_valid,
   input  wire logic               i_work_start,
   input  wire logic [1:0]         i_delay,
   input  wire logic               i_fail_exec,
   input  wire logic [31:0]        i_reg_value,
   output logic                    o_ack,
   output logic [31:0]             o_host_data,
   output logic                    o_host_data_valid,
   output logic                    o_exec_done,
   output logic                    o_exec_exception
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcd_pkg::*;
   int   wait_cnt;
   int   exec_cnt;
   logic took_reg;
   initial
   begin
      o_ack = 1'b0;
      o_host_data = 32'h0000_0000;
      o_host_data_valid = 1'b0;
      o_exec_done = 1'b0;
      o_exec_exception = 1'b0;
      took_reg = 1'b0;
   end
   always @(posedge i_clk)
      took_reg <= o_ack && i_resp_valid && i_resp.prim == PRIM_XFER_HOST_REG;
   // Outside its one-cycle slot the data bus toggles, so stale values are never mistaken for data.
   always @(negedge i_clk)
   begin
      o_host_data_valid = took_reg;
      o_host_data = took_reg ? i_reg_value : ~o_host_data;
      o_exec_done = 1'b0;
      o_exec_exception = 1'b0;
      if (i_rst || o_ack)
      begin
         o_ack = 1'b0;
         wait_cnt = 0;
      end
      else if (i_resp_valid)
      begin
         if (wait_cnt >= i_delay)
            o_ack = 1'b1;
         wait_cnt++;
      end
      if (i_rst)
         exec_cnt = 0;
      else if (i_work_start)
         exec_cnt = 3;
      else if (exec_cnt > 0)
      begin
         exec_cnt--;
         o_exec_done = exec_cnt == 0;
         o_exec_exception = exec_cnt == 0 && i_fail_exec;
      end
   end
endmodule
`default_nettype wire

// *** dv/fcd_decoder_tb_top.sv ***
`default_nettype none
module fcd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fcd_pkg::*;
   typedef struct packed {
      logic [15:0] cmd;
      logic [15:0] ctl;
      logic [1:0]  n;
      fcd_prim_t   first;
      logic        pc;
      logic        pc_chk;
      logic [3:0]  xlen;
      fcd_ea_t     xea;
   } fcd_row_t;
   localparam logic [3:0] FLEN [8] = '{LEN_4, LEN_4, LEN_12, LEN_12, LEN_2, LEN_8, LEN_1, LEN_12};
   localparam logic [3:0] CLEN [8] = '{LEN_4, LEN_4, LEN_4, LEN_8, LEN_4, LEN_8, LEN_8, LEN_12};
   localparam logic [6:0] RED [6] = '{7'h05, 7'h29, 7'h39, 7'h3F, 7'h2F, 7'h3B};
   localparam logic [15:0] UND [3] = '{16'h0440, 16'h047F, 16'h4C7F};
   logic        i_clk;
   logic        i_rst;
   logic        i_cmd_valid;
   logic [15:0] i_cmd_word;
   logic        o_cmd_ready;
   logic [15:0] i_float_control_reg;
   logic [31:0] i_host_data;
   logic        i_host_data_valid;
   logic        i_exec_done;
   logic        i_exec_exception;
   fcd_resp_t   o_resp;
   logic        o_resp_valid;
   logic        i_resp_ack;
   fcd_work_t   o_work;
   logic        o_work_start;
   logic [1:0]  delay;
   logic        fail_exec;
   logic [31:0] reg_value;
   fcd_resp_t   seen [$];
   fcd_work_t   work_seen;
   fcd_row_t    rows [$];
   int          n_fail;
   int          comparisons;
   fcd_decoder fcd_decoder_inst (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
      .i_cmd_word(i_cmd_word), .o_cmd_ready(o_cmd_ready), .i_float_control_reg(i_float_control_reg),
      .i_host_data(i_host_data), .i_host_data_valid(i_host_data_valid), .i_exec_done(i_exec_done),
      .i_exec_exception(i_exec_exception), .o_resp(o_resp), .o_resp_valid(o_resp_valid),
      .i_resp_ack(i_resp_ack), .o_work(o_work), .o_work_start(o_work_start));
   fcd_host_model fcd_host_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_resp(o_resp),
      .i_resp_valid(o_resp_valid), .i_work_start(o_work_start), .i_delay(delay), .i_fail_exec(fail_exec),
      .i_reg_value(reg_value), .o_ack(i_resp_ack), .o_host_data(i_host_data),
      .o_host_data_valid(i_host_data_valid), .o_exec_done(i_exec_done), .o_exec_exception(i_exec_exception));
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      if (o_resp_valid && i_resp_ack)
         seen.push_back(o_resp);
      if (o_work_start)
         work_seen <= o_work;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 200; i++)
      begin
         @(negedge i_clk);
         if (o_cmd_ready === 1'b1)
            return;
      end
      n_fail++;
      $display("Error at %0t: no return to idle", $time);
      tally_and_finish();
   endtask
   task automatic run(input logic [15:0] cmd, input logic [15:0] ctl);
      wait_idle();
      seen.delete();
      i_cmd_word = cmd;
      i_float_control_reg = ctl;
      i_cmd_valid = 1'b1;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      wait_idle();
   endtask
   task automatic check_row(input fcd_row_t r);
      run(r.cmd, r.ctl);
      check(seen.size(), r.n);
      if (seen.size() != r.n)
         return;
      check(seen[0].prim, r.first);
      if (r.pc_chk)
         check(seen[0].pass_counter_bit, r.pc);
      if (r.first == PRIM_PRE_EXC)
         check(seen[0].vector, UNIMP_VECTOR);
      else
         check({seen[r.n - 1].prim, seen[r.n - 1].come_again_bit}, {PRIM_NULL, 1'b0});
      foreach (seen[k])
      begin
         if (r.xlen != 4'h0 && seen[k].prim == PRIM_EVAL_XFER)
         begin
            check({seen[k].length, seen[k].come_again_bit}, {r.xlen, 1'b1});
            if (r.cmd[15])
               check(seen[k].dir_to_host, r.cmd[13]);
            else
               check(seen[k].ea_class, r.xea);
         end
      end
   endtask
   function automatic fcd_row_t mk(logic [15:0] c, logic [15:0] t, logic [1:0] n, fcd_prim_t f,
                                   logic p, logic pk, logic [3:0] l, fcd_ea_t e);
      return '{c, t, n, f, p, pk, l, e};
   endfunction
   initial
   begin
      i_rst = 1'b1;
      i_cmd_valid = 1'b0;
      i_cmd_word = 16'h0000;
      i_float_control_reg = 16'h0000;
      delay = 2'd0;
      fail_exec = 1'b0;
      reg_value = 32'h0000_0000;
      n_fail = 0;
      comparisons = 0;
      repeat (4) @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      check({o_cmd_ready, o_resp_valid, o_work_start}, 3'b100);
      rows.push_back(mk(16'h0422, 16'h4000, 2'd2, PRIM_NULL, 1'b1, 1'b1, 4'h0, EA_ANY));
      rows.push_back(mk(16'h0422, 16'h8000, 2'd2, PRIM_NULL, 1'b0, 1'b1, 4'h0, EA_ANY));
      foreach (RED[i])
         rows.push_back(mk(16'h0480 | {9'h000, RED[i]}, 16'h0000, 2'd2, PRIM_NULL, 1'b0, 1'b1, 4'h0, EA_ANY));
      foreach (UND[i])
         rows.push_back(mk(UND[i], 16'h0100, 2'd1, PRIM_PRE_EXC, 1'b0, 1'b0, 4'h0, EA_ANY));
      for (int f = 0; f < 7; f++)
      begin
         rows.push_back(mk(16'h4122 | 16'(f << 10), 16'h0100, 2'd2, PRIM_EVAL_XFER, 1'b1, 1'b1, FLEN[f],
                           (f == 0 || f == 1 || f == 4 || f == 6) ? EA_DATA : EA_MEMORY));
         rows.push_back(mk(16'h6180 | 16'(f << 10) | (f == 3 ? 16'h007E : 16'h0000), 16'h0100, 2'd3,
                           PRIM_NULL, 1'b1, 1'b1, FLEN[f], (f == 0 || f == 1 || f == 4 || f == 6) ? EA_DATA : EA_MEMORY));
      end
      rows.push_back(mk(16'h7580, 16'h8000, 2'd2, PRIM_EVAL_XFER, 1'b0, 1'b0, LEN_8, EA_MEMORY));
      rows.push_back(mk(16'h5D8B, 16'h0200, 2'd2, PRIM_NULL, 1'b1, 1'b1, 4'h0, EA_ANY));
      rows.push_back(mk(16'h5D8B, 16'h8000, 2'd1, PRIM_NULL, 1'b0, 1'b0, 4'h0, EA_ANY));
      for (int c = 0; c < 16; c++)
         rows.push_back(mk(16'h8000 | 16'(c << 10) | (c > 7 ? 16'h02AA : 16'h0000), 16'h0100, 2'd2,
                           PRIM_EVAL_XFER, 1'b0, 1'b0, CLEN[c % 8], EA_ANY));
      foreach (rows[i])
      begin
         delay = 2'(i);
         check_row(rows[i]);
      end
      reg_value = 32'hFFFF_FF85;
      run(16'h7CD5, 16'h0000);
      check(seen.size(), 3);
      check({seen[0].prim, seen[0].host_reg}, {PRIM_XFER_HOST_REG, 3'd5});
      check(work_seen.k_factor, 7'h05);
      run(16'hD0F0, 16'h0000);
      check({seen[0].prim, seen[0].ea_class}, {PRIM_XFER_MULT, EA_CONTROL});
      check(work_seen.mult_list, 8'hF0);
      reg_value = 32'h0000_00A5;
      run(16'hE830, 16'h0000);
      check({seen[0].prim, seen[0].host_reg}, {PRIM_XFER_HOST_REG, 3'd3});
      check(work_seen.mult_list, 8'hA5);
      fail_exec = 1'b1;
      run(16'h4122, 16'h0000);
      check(seen[seen.size() - 1].prim, PRIM_MID_EXC);
      fail_exec = 1'b0;
      wait_idle();
      i_cmd_word = 16'h4122;
      i_cmd_valid = 1'b1;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      i_rst = 1'b1;
      @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      check({o_cmd_ready, o_resp_valid, o_work_start}, 3'b100);
      check_row(rows[0]);
      tally_and_finish();
   end
endmodule
`default_nettype wire
